// [iosma_defs.svh]
// Address map, field positions and reset values for the I/O space block
`ifndef IOSMA_DEFS_SVH
`define IOSMA_DEFS_SVH
// ---------------------------------------------------------------
// I/O space map
// ---------------------------------------------------------------
`define IOSMA_SC_TOP 16'h003f
`define IOSMA_BIT_TOP 16'h001f
`define IOSMA_EXT_LO 16'h0040
`define IOSMA_EXT_TOP 16'h103f
`define IOSMA_KEY_ADDR 16'h1040
`define IOSMA_W16_BASE 16'h0a00
`define IOSMA_W24_BASE 16'h0a04
`define IOSMA_W32_BASE 16'h0a08
`define IOSMA_KEY_RST 32'h5cc5c55c
`define IOSMA_UNLOCK_VAL 32'h5cc5c55c
// ---------------------------------------------------------------
// Controller registers on AXI4-Lite (byte offsets)
// ---------------------------------------------------------------
`define IOSMA_A_CMD 5'h00
`define IOSMA_A_ADDR 5'h04
`define IOSMA_A_WDATA 5'h08
`define IOSMA_A_RDATA 5'h0c
`define IOSMA_A_STAT 5'h10
`define IOSMA_CMD_OP_LSB 0
`define IOSMA_CMD_LEN_LSB 4
`define IOSMA_CMD_BIT_LSB 8
`define IOSMA_ST_BUSY 0
`define IOSMA_ST_ERR 1
`define IOSMA_ST_SKIP 2
`define IOSMA_RESP_OKAY 2'h0
`define IOSMA_RESP_SLVERR 2'h2
`endif

// [iosma_pkg.sv]
// Types shared by both ends of the I/O space link
package iosma_pkg;
   // Access kinds issued by the CPU side
   typedef enum logic [3:0] {
      IOSMA_NOP,
      IOSMA_IN,
      IOSMA_OUT,
      IOSMA_SET_BIT,
      IOSMA_CLR_BIT,
      IOSMA_SKIP_SET,
      IOSMA_SKIP_CLR,
      IOSMA_LOAD,
      IOSMA_STORE
   } iosma_op_t;
   typedef enum {IOSMA_IDLE, IOSMA_BUSY} iosma_state_t;
endpackage

// [iosma_if.sv]
// Byte-wide I/O access link between CPU side and device side
`timescale 1ns/1ns
`default_nettype none
interface iosma_if;
   import iosma_pkg::*;
   iosma_op_t op;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [2:0] bitsel;
   logic [7:0] rdata;
   logic ack;
   logic skip;
   logic err;
   modport dev (input op, addr, wdata, bitsel, output rdata, ack, skip, err);
   modport cpu (output op, addr, wdata, bitsel, input rdata, ack, skip, err);
endinterface
`default_nettype wire

// [iosma_dev.sv]
// Device end: I/O register space with staged wide registers and lock key
// Operation
// - Unlocked only when key equals unlock value
// - Key read-only; initial content is unlock value
// - In/out reach addresses 0x00 to 0x3f
// - Bit set/clear on addresses 0x00 to 0x1f
// - Skip instructions test any bit there
// - Extended range reachable only by load/store
// - Software writes reserved bits as zero
// - Software never writes reserved addresses
// - Wide registers reached through staging bytes
// - Write low byte before high byte
// - Low byte write loads staging byte only
// - High byte write commits staging byte too
// - Read low byte before high byte
// - Low byte read snapshots high byte
// - High byte read returns staging byte
// - Wide accesses not interleaved by interrupts
// - Two staging bytes 24-bit, three 32-bit
// - Write MSB last, read LSB first
`timescale 1ns/1ns
`default_nettype none
`include "iosma_defs.svh"
module iosma_dev
   import iosma_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   iosma_if.dev bus,
   input wire logic key_prog,
   input wire logic [31:0] key_prog_data,
   output logic unlocked,
   output logic [15:0] wide16_q,
   output logic [23:0] wide24_q,
   output logic [31:0] wide32_q
);
   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   logic is_io, is_bit, is_skip, is_mem, is_wr, is_rd, active;
   logic in_sc, in_bitr, in_ext, key_hit, legal;
   logic [7:0] bmask;

   // Range checks decide which access kinds may touch an address
   assign is_io = (bus.op == IOSMA_IN) || (bus.op == IOSMA_OUT);
   assign is_skip = (bus.op == IOSMA_SKIP_SET) || (bus.op == IOSMA_SKIP_CLR);
   assign is_bit = is_skip || (bus.op == IOSMA_SET_BIT) ||
                   (bus.op == IOSMA_CLR_BIT);
   assign is_mem = (bus.op == IOSMA_LOAD) || (bus.op == IOSMA_STORE);
   assign is_wr = (bus.op == IOSMA_OUT) || (bus.op == IOSMA_STORE) ||
                  (bus.op == IOSMA_SET_BIT) || (bus.op == IOSMA_CLR_BIT);
   assign is_rd = (bus.op == IOSMA_IN) || (bus.op == IOSMA_LOAD);
   assign active = bus.op != IOSMA_NOP;
   assign in_sc = bus.addr <= `IOSMA_SC_TOP;
   assign in_bitr = bus.addr <= `IOSMA_BIT_TOP;
   assign in_ext = (bus.addr >= `IOSMA_EXT_LO) && (bus.addr <= `IOSMA_EXT_TOP);
   assign key_hit = bus.addr[15:2] == 14'(`IOSMA_KEY_ADDR >> 2);
   // Key bytes answer loads only; a store to them is refused
   assign legal = (is_io && in_sc)
               || (is_bit && in_bitr)
               || (is_mem && (in_sc || in_ext))
               || ((bus.op == IOSMA_LOAD) && key_hit);
   assign bmask = 8'h01 << bus.bitsel;

   // ---------------------------------------------------------------
   // Bit-addressable scratch bytes
   // ---------------------------------------------------------------
   logic [7:0] scr_r [0:31];
   logic [7:0] scr_cur, scr_nxt;

   // Bit ops are read-modify-write on one byte in a single access
   assign scr_cur = scr_r[bus.addr[4:0]];
   assign scr_nxt = (bus.op == IOSMA_SET_BIT) ? (scr_cur | bmask) :
                    (bus.op == IOSMA_CLR_BIT) ? (scr_cur & ~bmask) :
                    bus.wdata;

   genvar e;
   generate
      for (e = 0; e < 32; e = e + 1) begin : g_scr
         logic wr_hit;
         assign wr_hit = legal && is_wr && in_bitr &&
                         (bus.addr[4:0] == 5'(e));
         always_ff @(posedge core_clk) begin
            if (rst) begin
               scr_r[e] <= 8'h00;
            end else if (wr_hit) begin
               scr_r[e] <= scr_nxt;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Wide registers: 16, 24 and 32 bits, each with its own staging
   // ---------------------------------------------------------------
   logic [7:0] wide_rd [0:2];
   logic [2:0] wide_hit;
   logic [31:0] wide_val [0:2];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_wide
         localparam int NB = g + 2;
         localparam logic [15:0] BASE = (g == 0) ? `IOSMA_W16_BASE :
                                        (g == 1) ? `IOSMA_W24_BASE :
                                        `IOSMA_W32_BASE;
         localparam logic [31:0] LOWMASK = (32'h1 << (8 * (NB - 1))) - 32'h1;
         logic [31:0] val_r, commit;
         logic [23:0] tmp_r;
         logic [15:0] off;
         logic [1:0] idx;
         logic hit, last;

         assign off = bus.addr - BASE;
         assign idx = off[1:0];
         assign hit = legal && is_mem && (bus.addr >= BASE) &&
                      (off < 16'(NB));
         assign last = idx == 2'(NB - 1);
         // Top byte plus every staged lower byte land together
         assign commit = ({8'h00, tmp_r} & LOWMASK) |
                         ({24'h000000, bus.wdata} << (8 * (NB - 1)));
         // High bytes come from staging, not the live value
         assign wide_rd[g] = !hit ? 8'h00 :
                             (idx == 2'd0) ? val_r[7:0] :
                             tmp_r[8 * (idx - 2'd1) +: 8];
         assign wide_hit[g] = hit;
         assign wide_val[g] = val_r;

         // Staging is shared by reads and writes, as one temp per register
         always_ff @(posedge core_clk) begin
            if (rst) begin
               val_r <= 32'h00000000;
               tmp_r <= 24'h000000;
            end else if (hit && is_wr && last) begin
               val_r <= commit;
            end else if (hit && is_wr) begin
               tmp_r[8 * idx +: 8] <= bus.wdata;
            end else if (hit && is_rd && (idx == 2'd0)) begin
               tmp_r <= val_r[31:8];
            end
         end
      end
   endgenerate

   assign wide16_q = wide_val[0][15:0];
   assign wide24_q = wide_val[1][23:0];
   assign wide32_q = wide_val[2];

   // ---------------------------------------------------------------
   // Lock key word
   // ---------------------------------------------------------------
   logic [31:0] key_r;
   logic unlocked_r;

   // Only the fuse programming port changes the key; the bus never does
   always_ff @(posedge core_clk) begin
      if (rst) begin
         key_r <= `IOSMA_KEY_RST;
      end else if (key_prog) begin
         key_r <= key_prog_data;
      end
   end

   // Any value other than the unlock pattern means locked
   always_ff @(posedge core_clk) begin
      if (rst) begin
         unlocked_r <= 1'b0;
      end else begin
         unlocked_r <= key_r == `IOSMA_UNLOCK_VAL;
      end
   end
   assign unlocked = unlocked_r;

   // ---------------------------------------------------------------
   // Answer path: one cycle after each access
   // ---------------------------------------------------------------
   logic [7:0] rd_byte, rdata_r;
   logic ack_r, skip_r, err_r, bit_val;

   // Reserved holes read as zero
   assign rd_byte = (in_bitr) ? scr_cur :
                    (|wide_hit) ? (wide_rd[0] | wide_rd[1] | wide_rd[2]) :
                    (key_hit) ? key_r[8 * bus.addr[1:0] +: 8] :
                    8'h00;
   assign bit_val = |(scr_cur & bmask);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         skip_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         ack_r <= active;
         err_r <= active && !legal;
         skip_r <= legal && is_skip &&
                   (bit_val == (bus.op == IOSMA_SKIP_SET));
         rdata_r <= (legal && is_rd) ? rd_byte : 8'h00;
      end
   end

   assign bus.ack = ack_r;
   assign bus.err = err_r;
   assign bus.skip = skip_r;
   assign bus.rdata = rdata_r;
endmodule // iosma_dev
`default_nettype wire

// [iosma_cpu.sv]
// CPU end: AXI4-Lite command registers driving ordered byte accesses
`timescale 1ns/1ns
`default_nettype none
`include "iosma_defs.svh"
module iosma_cpu
   import iosma_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   iosma_if.cpu bus,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic awready_r, wready_r, bvalid_r, aw_have, w_have, arready_r, rvalid_r;
   logic [4:0] awaddr_r;
   logic [31:0] wdat_r, axi_rdata_r, cmd_wdata_r, cmd_rdata_r, rd_mux;
   logic [1:0] bresp_r, rresp_r;
   logic do_wr, wr_map, rd_map;
   logic [15:0] cmd_addr_r;
   iosma_state_t state_r;
   logic err_r, skip_r;

   assign do_wr = aw_have && w_have && !bvalid_r;
   assign wr_map = (awaddr_r == `IOSMA_A_CMD) || (awaddr_r == `IOSMA_A_ADDR) ||
                   (awaddr_r == `IOSMA_A_WDATA);
   assign rd_map = (s_axi_araddr <= `IOSMA_A_STAT) &&
                   (s_axi_araddr[1:0] == 2'b00);
   assign rd_mux = (s_axi_araddr == `IOSMA_A_CMD) ? 32'h00000000 :
                   (s_axi_araddr == `IOSMA_A_ADDR) ? {16'h0000, cmd_addr_r} :
                   (s_axi_araddr == `IOSMA_A_WDATA) ? cmd_wdata_r :
                   (s_axi_araddr == `IOSMA_A_RDATA) ? cmd_rdata_r :
                   (s_axi_araddr == `IOSMA_A_STAT) ?
                   {29'h00000000, skip_r, err_r, state_r == IOSMA_BUSY} :
                   32'h00000000;

   // Address and data are taken in either order; response follows both
   always_ff @(posedge core_clk) begin
      if (rst) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `IOSMA_RESP_OKAY;
         awaddr_r <= 5'h00;
         wdat_r <= 32'h00000000;
      end else begin
         if (awready_r && s_axi_awvalid) begin
            awaddr_r <= s_axi_awaddr;
            aw_have <= 1'b1;
            awready_r <= 1'b0;
         end
         if (wready_r && s_axi_wvalid) begin
            wdat_r <= s_axi_wdata;
            w_have <= 1'b1;
            wready_r <= 1'b0;
         end
         if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? `IOSMA_RESP_OKAY : `IOSMA_RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Read data is answered one cycle after the address is taken
   always_ff @(posedge core_clk) begin
      if (rst) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         axi_rdata_r <= 32'h00000000;
         rresp_r <= `IOSMA_RESP_OKAY;
      end else if (arready_r && s_axi_arvalid) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         axi_rdata_r <= rd_mux;
         rresp_r <= rd_map ? `IOSMA_RESP_OKAY : `IOSMA_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = axi_rdata_r;
   assign s_axi_rresp = rresp_r;

   // ---------------------------------------------------------------
   // Byte sequencer
   // ---------------------------------------------------------------
   iosma_op_t op_r, cur_op_r, new_op;
   logic [1:0] len_r, idx_r, new_len;
   logic [2:0] bit_r;
   logic [15:0] addr_r, span_end;
   logic [7:0] wdata_r;
   logic start, new_wr, refuse, done;

   assign new_op = iosma_op_t'(wdat_r[`IOSMA_CMD_OP_LSB +: 4]);
   // Bit ops always touch a single byte
   assign new_len = (new_op == IOSMA_LOAD) || (new_op == IOSMA_STORE) ||
                    (new_op == IOSMA_IN) || (new_op == IOSMA_OUT) ?
                    wdat_r[`IOSMA_CMD_LEN_LSB +: 2] : 2'd0;
   assign new_wr = (new_op == IOSMA_OUT) || (new_op == IOSMA_STORE) ||
                   (new_op == IOSMA_SET_BIT) || (new_op == IOSMA_CLR_BIT);
   assign span_end = cmd_addr_r + {14'h0000, new_len};
   // Writes past the key word never reach the link; the key refuses its own
   assign refuse = new_wr &&
                   (span_end > (`IOSMA_KEY_ADDR + 16'h0003));
   // A command written while busy is dropped, so sequences never interleave
   assign start = do_wr && (awaddr_r == `IOSMA_A_CMD) &&
                  (state_r == IOSMA_IDLE);
   assign done = bus.ack && (idx_r == len_r);

   // Bytes go out in rising address order: LSB read first, MSB write last
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= IOSMA_IDLE;
         op_r <= IOSMA_NOP;
         cur_op_r <= IOSMA_NOP;
         len_r <= 2'd0;
         idx_r <= 2'd0;
         bit_r <= 3'd0;
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         err_r <= 1'b0;
         skip_r <= 1'b0;
         cmd_addr_r <= 16'h0000;
         cmd_wdata_r <= 32'h00000000;
         cmd_rdata_r <= 32'h00000000;
      end else begin
         op_r <= IOSMA_NOP;
         if (do_wr && (awaddr_r == `IOSMA_A_ADDR) && (state_r == IOSMA_IDLE)) begin
            cmd_addr_r <= wdat_r[15:0];
         end
         if (do_wr && (awaddr_r == `IOSMA_A_WDATA) && (state_r == IOSMA_IDLE)) begin
            cmd_wdata_r <= wdat_r;
         end
         case (state_r)
            IOSMA_IDLE: begin
               if (start && refuse) begin
                  err_r <= 1'b1;
                  skip_r <= 1'b0;
               end else if (start) begin
                  state_r <= IOSMA_BUSY;
                  op_r <= new_op;
                  cur_op_r <= new_op;
                  len_r <= new_len;
                  idx_r <= 2'd0;
                  bit_r <= wdat_r[`IOSMA_CMD_BIT_LSB +: 3];
                  addr_r <= cmd_addr_r;
                  wdata_r <= cmd_wdata_r[7:0];
                  err_r <= 1'b0;
                  skip_r <= 1'b0;
                  cmd_rdata_r <= 32'h00000000;
               end
            end
            IOSMA_BUSY: begin
               if (bus.ack) begin
                  cmd_rdata_r[8 * idx_r +: 8] <= bus.rdata;
                  err_r <= err_r | bus.err;
                  skip_r <= bus.skip;
               end
               if (done) begin
                  state_r <= IOSMA_IDLE;
               end else if (bus.ack) begin
                  idx_r <= idx_r + 2'd1;
                  op_r <= cur_op_r;
                  addr_r <= addr_r + 16'h0001;
                  wdata_r <= cmd_wdata_r[8 * (idx_r + 2'd1) +: 8];
               end
            end
            default: begin
               state_r <= IOSMA_IDLE;
            end
         endcase
      end
   end

   assign bus.op = op_r;
   assign bus.addr = addr_r;
   assign bus.wdata = wdata_r;
   assign bus.bitsel = bit_r;
endmodule // iosma_cpu
`default_nettype wire

// [iosma_props.sv]
// Link-level assertions for the I/O space block
`timescale 1ns/1ns
`default_nettype none
module iosma_props
   import iosma_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input var iosma_op_t op,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [2:0] bitsel,
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic skip,
   input wire logic err
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Access classes
   // ------------------------------------------------------------
   // Decoded once so each property stays a short relation
   wire io_op = (op == IOSMA_IN) || (op == IOSMA_OUT);
   wire ls_op = (op == IOSMA_LOAD) || (op == IOSMA_STORE);
   wire sk_op = (op == IOSMA_SKIP_SET) || (op == IOSMA_SKIP_CLR);
   wire bit_op = sk_op || (op == IOSMA_SET_BIT) || (op == IOSMA_CLR_BIT);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   AST_ACK_NEXT: assert property (op != IOSMA_NOP |=> ack)
      else $error("no answer one cycle after an access");
   AST_ACK_CAUSE: assert property (ack |-> $past(op) != IOSMA_NOP)
      else $error("answer without an access");
   AST_IO_OK: assert property (io_op && addr <= 16'h003f |=> !err)
      else $error("in or out refused inside the fast range");
   AST_IO_EXT: assert property (io_op && addr > 16'h003f |=> err)
      else $error("in or out accepted outside the fast range");
   AST_BIT_OK: assert property (bit_op && addr <= 16'h001f
      |=> !err)
      else $error("bit access refused in the bit range");
   AST_BIT_FAR: assert property (bit_op && addr > 16'h001f
      |=> err)
      else $error("bit access accepted outside the bit range");
   AST_EXT_LS: assert property (ls_op && addr >= 16'h0040
      && addr <= 16'h103f |=> !err)
      else $error("load or store refused in the extended range");
   AST_KEY_RO: assert property (op == IOSMA_STORE
      && addr >= 16'h1040 && addr <= 16'h1043 |=> err ##0 rdata == 8'h00)
      else $error("store to the key word not refused");
   AST_SKIP_SRC: assert property (skip |-> ack && $past(sk_op)
      && $past(addr) <= 16'h001f)
      else $error("skip flag without a legal bit test");
   AST_ERR_QUIET: assert property (err |-> ack && !skip
      && rdata == 8'h00)
      else $error("refused access carried data or skip");
   COV_ERR: cover property (err);
   COV_SKIP: cover property (skip);
   COV_WIDE: cover property (ls_op && addr[15:8] == 8'h0a ##1 ack);
endmodule // iosma_props
`default_nettype wire

// [tb.sv]
// Self-checking bench joining both ends of the I/O space link
`timescale 1ns/1ns
`default_nettype none
`include "iosma_defs.svh"
module tb;
   import iosma_pkg::*;
   typedef struct packed {logic [31:0] d; logic [31:0] m;} iosma_note_t;
   logic core_clk, unlocked;
   logic rst = 1'b1, key_prog = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
   logic arv = 1'b0, rre = 1'b0, awr, wr, bv, arr, rv;
   logic [4:0] awa = 5'h00, ara = 5'h00;
   logic [31:0] key_prog_data = 32'h0, wd = 32'h0, rd, last_rd, v, x;
   logic [1:0] br, rr;
   logic [15:0] w16;
   logic [23:0] w24;
   logic [31:0] w32;
   logic [31:0] wq [3];
   logic [31:0] mk;
   iosma_note_t nt;
   iosma_note_t rq[$];
   logic [1:0] bq[$];
   int error_cnt = 0, checks_done = 0, k;
   assign wq[0] = {16'h0, w16};
   assign wq[1] = {8'h0, w24};
   assign wq[2] = w32;
   iosma_if iosma_if_inst();
   iosma_dev iosma_dev_inst (.core_clk(core_clk), .rst(rst),
      .bus(iosma_if_inst), .key_prog(key_prog),
      .key_prog_data(key_prog_data), .unlocked(unlocked),
      .wide16_q(w16), .wide24_q(w24), .wide32_q(w32));
   iosma_cpu iosma_cpu_inst (.core_clk(core_clk), .rst(rst),
      .bus(iosma_if_inst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
   iosma_props iosma_props_inst (.core_clk(core_clk), .rst(rst),
      .op(iosma_if_inst.op), .addr(iosma_if_inst.addr),
      .wdata(iosma_if_inst.wdata), .bitsel(iosma_if_inst.bitsel),
      .rdata(iosma_if_inst.rdata), .ack(iosma_if_inst.ack),
      .skip(iosma_if_inst.skip), .err(iosma_if_inst.err));
   // ------------------------------------------------------------
   // Reporting and comparison
   // ------------------------------------------------------------
   task automatic fail(input string s);
      $display("unexpected at %0t: %s", $time, s);
      error_cnt++;
   endtask
   task automatic end_sim;
      $display("errors %0d, checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
      checks_done++;
      if (g !== e) fail("bus response");
   endtask
   task automatic cmp_data(input logic [31:0] g, input logic [31:0] e,
                           input logic [31:0] m);
      checks_done++;
      if ((g & m) !== (e & m)) fail("data value");
   endtask
   // ------------------------------------------------------------
   // Register bus master; each task leaves one idle edge behind
   // ------------------------------------------------------------
   task automatic axw(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] e);
      int n;
      bq.push_back(e);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      bre <= 1'b0;
      if (n == 40) fail("write timeout");
      if (n == 40) end_sim();
      @(posedge core_clk);
   endtask
   task automatic axr(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m);
      int n;
      rq.push_back({e, m});
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      last_rd = rd;
      rre <= 1'b0;
      if (n == 40) fail("read timeout");
      if (n == 40) end_sim();
      @(posedge core_clk);
   endtask
   // One link command: st is {skip, err, busy}, ex/m the read-back word
   task automatic io(input iosma_op_t o, input logic [15:0] a,
                     input logic [1:0] l, input logic [2:0] b,
                     input logic [31:0] w, input logic [2:0] st,
                     input logic [31:0] ex, input logic [31:0] m);
      int n;
      axw(`IOSMA_A_ADDR, {16'h0, a}, `IOSMA_RESP_OKAY);
      axw(`IOSMA_A_WDATA, w, `IOSMA_RESP_OKAY);
      axw(`IOSMA_A_CMD, {21'h0, b, 2'h0, l, o}, `IOSMA_RESP_OKAY);
      for (n = 0; n < 20; n++) begin
         axr(`IOSMA_A_STAT, 32'h0, 32'h0);
         if (last_rd[0] === 1'b0) break;
      end
      if (n == 20) fail("busy timeout");
      if (n == 20) end_sim();
      axr(`IOSMA_A_STAT, {29'h0, st}, 32'h7);
      axr(`IOSMA_A_RDATA, ex, m);
   endtask
   // Fuse key load; unlocked settles two edges after the strobe
   task automatic prog_key(input logic [31:0] kv, input logic e);
      key_prog <= 1'b1;
      key_prog_data <= kv;
      @(posedge core_clk);
      key_prog <= 1'b0;
      repeat (2) @(posedge core_clk);
      cmp_data({31'h0, unlocked}, {31'h0, e}, 32'h1);
   endtask
   // Result watcher: oldest note against each handshake seen
   always @(posedge core_clk) begin
      if (bv && bre) begin
         if (bq.size() == 0) fail("spare write response");
         else cmp_resp(br, bq.pop_front());
      end
      if (rv && rre) begin
         if (rq.size() == 0) fail("spare read data");
         nt = (rq.size() == 0) ? '0 : rq.pop_front();
         // Every bench read targets a mapped word
         cmp_resp(rr, `IOSMA_RESP_OKAY);
         if (nt.m != 32'h0) cmp_data(rd, nt.d, nt.m);
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      v = $urandom(32'h5381);
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      cmp_data({31'h0, unlocked}, 32'h1, 32'h1);
      io(IOSMA_STORE, 16'h1040, 0, 0, 32'h0, 3'b010, 0, 0);
      io(IOSMA_STORE, 16'h1044, 0, 0, 32'h0, 3'b010, 0, 0);
      io(IOSMA_LOAD, 16'h1040, 3, 0, 0, 0, `IOSMA_KEY_RST, '1);
      // Bit 0 of the unlock value is clear, so this key always locks
      v = $urandom() | 32'h1;
      prog_key(v, 1'b0);
      io(IOSMA_LOAD, 16'h1040, 3, 0, 0, 0, v, '1);
      prog_key(`IOSMA_UNLOCK_VAL, 1'b1);
      v = $urandom();
      io(IOSMA_OUT, 16'h001c, 0, 0, v, 0, 0, 0);
      io(IOSMA_IN, 16'h001c, 0, 0, 0, 0, v, 32'hff);
      io(IOSMA_IN, 16'h003f, 0, 0, 0, 0, 0, 32'hff);
      io(IOSMA_OUT, 16'h0040, 0, 0, v, 3'b010, 0, 0);
      io(IOSMA_IN, 16'h103f, 0, 0, 0, 3'b010, 0, 32'hff);
      io(IOSMA_STORE, 16'h103f, 0, 0, v, 0, 0, 0);
      io(IOSMA_LOAD, 16'h0040, 0, 0, 0, 0, 0, 32'hff);
      for (k = 0; k < 8; k++) begin
         io(IOSMA_SKIP_SET, 16'h001c, 0, k, 0, {v[k], 2'b0},
            0, 0);
         io(IOSMA_SKIP_CLR, 16'h001c, 0, k, 0, {~v[k], 2'b0},
            0, 0);
      end
      io(IOSMA_SET_BIT, 16'h001c, 0, 7, 0, 0, 0, 0);
      io(IOSMA_CLR_BIT, 16'h001c, 0, 0, 0, 0, 0, 0);
      io(IOSMA_IN, 16'h001c, 0, 0, 0, 0, (v | 8'h80) & 8'hfe,
         32'hff);
      io(IOSMA_SET_BIT, 16'h0020, 0, 1, 0, 3'b010, 0, 0);
      // Whole-width store then load for 16, 24 and 32 bits
      for (k = 0; k < 3; k++) begin
         v = $urandom();
         mk = (k == 0) ? 32'hffff : (k == 1) ? 32'hffffff : '1;
         io(IOSMA_STORE, 16'h0a00 + 16'(4 * k), 2'(k + 1), 0, v, 0, 0,
            0);
         if (k == 0) x = v;
         cmp_data(wq[k], v, mk);
         io(IOSMA_LOAD, 16'h0a00 + 16'(4 * k), 2'(k + 1), 0, 0, 0, v,
            mk);
      end
      // Split 16-bit write: low byte only stages, high byte commits both
      mk = $urandom();
      io(IOSMA_STORE, 16'h0a00, 0, 0, mk, 0, 0, 0);
      cmp_data({16'h0, w16}, x, 32'hff00);
      cmp_data({16'h0, w16}, x, 32'h00ff);
      cmp_data(w32, v, 32'hffffffff);
      io(IOSMA_LOAD, 16'h0a01, 0, 0, 0, 0, mk, 32'hff);
      io(IOSMA_STORE, 16'h0a01, 0, 0, mk >> 8, 0, 0, 0);
      cmp_data({16'h0, w16}, mk, 32'hffff);
      axw(5'h14, 32'h0, `IOSMA_RESP_SLVERR);
      end_sim();
   end
endmodule // tb
`default_nettype wire
